/* File: src/gate_drive_defs.vh */
`ifndef GATE_DRIVE_DEFS_VH
`define GATE_DRIVE_DEFS_VH

// =============================================================
// pin synchroniser slots
`define PIN_COUNT         12
`define PIN_DRV0          0
`define PIN_DRV1          1
`define PIN_DRV2          2
`define PIN_PRI_EN        3
`define PIN_PRI_LVL       4
`define PIN_PWM_POS       5
`define PIN_PWM_NEG       6
`define PIN_SEC_EN        7
`define PIN_SEC_LVL       8
`define PIN_SCLK          9
`define PIN_CS_N          10
`define PIN_SDI           11

// =============================================================
// output stages and drive-strength decode
`define STAGE_W           2
`define STAGE_NONE        2'h0
`define STAGE_BOTH        2'h3
`define DRV_SEL_W         3
`define DRV_ALL_HIGH      3'h7

// =============================================================
// serial port framing
`define SPI_FRAME_BITS    16
`define SPI_CNT_W         5
`define SPI_CNT_ZERO      5'h00
`define SPI_CNT_LAST      5'h0f
`define SPI_MSB           15

// =============================================================
// analog comparator
`define ADC_W             10

`endif

/* File: src/pin_sync.v */
`timescale 1ns/1ns
// =============================================================
// three-stage synchroniser with agreement filter
module pin_sync #(
    parameter RST_VAL = 1'b0            // level assumed while in reset
) (
    // clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // pin side
    input  wire pin_in,
    // synchronous side
    output reg  level_reg
);

    reg s1_reg;                         // metastability catcher, read only by s2
    reg s2_reg;                         // second stage
    reg s3_reg;                         // third stage

    // shift chain; a change counts only once stages two and three agree
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            level_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

endmodule // pin_sync

/* File: src/gate_drive_input_control.v */
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
// How it works
// - all drive selects high: gate low, faults cleared
// - drive selects pick pull-up/pull-down stage combination
// - primary override enable: outputs follow override level
// - primary override off: pwm truth table decides
// - both pwm inputs active: guard forces gate low
// - positive pwm high pulls up, low pulls down
// - secondary override: ignore pwm, follow level pin; safe state in analog mode
// - secondary override off: primary pins govern output
// - dual-use pin defaults to secondary override level
// - analog mode: comparator flags above/below threshold fault
// - chip select high: output released, input ignored
// - serial input sampled on falling clock edge
// - serial output changes on rising clock edge
// - alarm low while unmasked comparator fault present
module gate_drive_input_control (
    // clock and reset
    input  wire                  clk_sys,
    input  wire                  resetn,
    // drive-strength select pins
    input  wire                  drive_select_bit0,
    input  wire                  drive_select_bit1,
    input  wire                  drive_select_bit2,
    // primary-side control pins
    input  wire                  primary_override_enable,
    input  wire                  primary_override_level,
    input  wire                  pwm_positive_input,
    input  wire                  pwm_negative_input,
    // secondary-side control pins
    input  wire                  secondary_override_enable,
    input  wire                  secondary_override_level,
    // configuration bits
    input  wire                  safe_state_level_select,
    input  wire                  second_input_analog_mode,
    input  wire                  cmp_above_select,
    input  wire [`ADC_W-1:0]     cmp_threshold,
    input  wire                  fault_mask,
    // digitised sample of the dual-use pin
    input  wire [`ADC_W-1:0]     adc_value,
    input  wire                  adc_valid,
    // gate stage commands
    output reg  [`STAGE_W-1:0]   gate_pullup_outputs,
    output reg  [`STAGE_W-1:0]   gate_pulldown_outputs,
    // fault reporting
    output reg                   first_fault_alarm_output,
    output reg                   cmp_fault_reg,
    output reg                   shoot_through_guard,
    // serial port pins
    input  wire                  spi_sclk,
    input  wire                  spi_cs_n,
    input  wire                  spi_sdi,
    output reg                   spi_sdo,
    output reg                   spi_sdo_oe,
    // serial port user side
    input  wire [`SPI_MSB:0]     spi_tx_word,
    output reg  [`SPI_MSB:0]     spi_rx_word,
    output reg                   spi_rx_strobe
);

    // =============================================================
    // reset release
    reg                   rst_meta_reg;     // first reset stage
    reg                   rst_n_reg;        // synchronised reset for the rest

    // async assert, sync release through two flops
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // =============================================================
    // pin synchronisers
    wire [`PIN_COUNT-1:0] pin_raw;          // pins in slot order
    wire [`PIN_COUNT-1:0] pin_s;            // filtered synchronous levels

    assign pin_raw = {spi_sdi, spi_cs_n, spi_sclk, secondary_override_level,
                      secondary_override_enable, pwm_negative_input,
                      pwm_positive_input, primary_override_level,
                      primary_override_enable, drive_select_bit2,
                      drive_select_bit1, drive_select_bit0};

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
            // chip select rests high so no frame is seen out of reset
            pin_sync #(
                .RST_VAL ((gi == `PIN_CS_N) ? 1'b1 : 1'b0)
            ) u_sync (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n_reg),
                .pin_in    (pin_raw[gi]),
                .level_reg (pin_s[gi])
            );
        end
    endgenerate

    // =============================================================
    // decode helpers
    // stage mask for a two-bit select; zero code means both stages
    function [`STAGE_W-1:0] stage_mask;
        input [1:0] sel;
        begin
            if (sel == `STAGE_NONE) begin
                stage_mask = `STAGE_BOTH;
            end else begin
                stage_mask = sel;
            end
        end
    endfunction

    wire [`DRV_SEL_W-1:0] drv_sel;          // synced drive-strength select
    wire                  drv_clear;        // all selects high
    wire [`STAGE_W-1:0]   up_mask;          // pull-up stages in use
    wire [`STAGE_W-1:0]   dn_mask;          // pull-down stages in use

    assign drv_sel   = pin_s[`PIN_DRV2:`PIN_DRV0];
    assign drv_clear = (drv_sel == `DRV_ALL_HIGH);
    // bits 0/1 pick the pull-up stages; bit 2 widens pull-down to both
    assign up_mask   = stage_mask(drv_sel[1:0]);
    assign dn_mask   = drv_sel[2] ? `STAGE_BOTH : up_mask;

    // =============================================================
    // gate level resolution
    reg  gate_on;                           // resolved gate command
    reg  overlap;                           // pwm overlap seen

    // priority: select clear, secondary override, primary override, pwm
    always @* begin
        overlap = pin_s[`PIN_PWM_POS] & pin_s[`PIN_PWM_NEG];
        if (drv_clear) begin
            gate_on = 1'b0;
        end else if (pin_s[`PIN_SEC_EN]) begin
            // pwm ignored; analog mode loses the level pin, so safe state
            if (second_input_analog_mode) begin
                gate_on = safe_state_level_select;
            end else begin
                gate_on = pin_s[`PIN_SEC_LVL];
            end
        end else if (pin_s[`PIN_PRI_EN]) begin
            gate_on = pin_s[`PIN_PRI_LVL];
        end else if (overlap) begin
            gate_on = 1'b0;
        end else begin
            gate_on = pin_s[`PIN_PWM_POS];
        end
    end

    // registered stage commands; pull-up and pull-down never both active
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            gate_pullup_outputs   <= `STAGE_NONE;
            gate_pulldown_outputs <= `STAGE_BOTH;
            shoot_through_guard   <= 1'b0;
        end else begin
            if (gate_on) begin
                gate_pullup_outputs   <= up_mask;
                gate_pulldown_outputs <= `STAGE_NONE;
            end else begin
                gate_pullup_outputs   <= `STAGE_NONE;
                gate_pulldown_outputs <= drv_clear ? `STAGE_BOTH : dn_mask;
            end
            // guard flag only when the pwm path is in charge; the all-high
            // select outranks pwm, so an overlap under it is not reported
            shoot_through_guard <= overlap & ~pin_s[`PIN_SEC_EN]
                                   & ~pin_s[`PIN_PRI_EN] & ~drv_clear;
        end
    end

    // =============================================================
    // comparator fault and alarm
    wire cmp_trip;                          // threshold crossed this sample

    assign cmp_trip = second_input_analog_mode & adc_valid &
                      (cmp_above_select ? (adc_value > cmp_threshold)
                                        : (adc_value < cmp_threshold));

    // sticky fault; a trip in the clearing cycle still sets it
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cmp_fault_reg            <= 1'b0;
            first_fault_alarm_output <= 1'b1;
        end else begin
            if (cmp_trip) begin
                cmp_fault_reg <= 1'b1;
            end else if (drv_clear) begin
                cmp_fault_reg <= 1'b0;
            end
            // alarm tracks the fault as it stands, one cycle later
            first_fault_alarm_output <= ~(cmp_fault_reg & ~fault_mask);
        end
    end

    // =============================================================
    // serial port
    reg                   sclk_d_reg;       // previous filtered clock level
    reg                   cs_d_reg;         // previous filtered select level
    reg  [`SPI_MSB:0]     rx_sh_reg;        // receive shifter
    reg  [`SPI_MSB:0]     tx_sh_reg;        // transmit shifter
    reg  [`SPI_CNT_W-1:0] bit_cnt_reg;      // bits taken this frame
    wire                  cs_act;           // frame in progress
    wire                  sclk_fall;        // falling clock edge
    wire                  sclk_rise;        // rising clock edge
    wire                  cs_start;         // select just went low

    assign cs_act    = ~pin_s[`PIN_CS_N];
    assign sclk_fall = sclk_d_reg & ~pin_s[`PIN_SCLK];
    assign sclk_rise = ~sclk_d_reg & pin_s[`PIN_SCLK];
    assign cs_start  = cs_d_reg & cs_act;

    // shift engine; the host holding select low frames each word
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sclk_d_reg    <= 1'b0;
            cs_d_reg      <= 1'b1;
            rx_sh_reg     <= {`SPI_FRAME_BITS{1'b0}};
            tx_sh_reg     <= {`SPI_FRAME_BITS{1'b0}};
            bit_cnt_reg   <= `SPI_CNT_ZERO;
            spi_rx_word   <= {`SPI_FRAME_BITS{1'b0}};
            spi_rx_strobe <= 1'b0;
            spi_sdo       <= 1'b0;
            spi_sdo_oe    <= 1'b0;
        end else begin
            sclk_d_reg    <= pin_s[`PIN_SCLK];
            cs_d_reg      <= pin_s[`PIN_CS_N];
            spi_rx_strobe <= 1'b0;
            spi_sdo_oe    <= cs_act;
            if (!cs_act) begin
                // deselected: data input ignored, count rearmed
                bit_cnt_reg <= `SPI_CNT_ZERO;
            end else if (cs_start) begin
                // first bit must be ready before the first falling edge
                tx_sh_reg   <= {spi_tx_word[`SPI_MSB-1:0], 1'b0};
                spi_sdo     <= spi_tx_word[`SPI_MSB];
                bit_cnt_reg <= `SPI_CNT_ZERO;
            end else begin
                if (sclk_fall) begin
                    rx_sh_reg <= {rx_sh_reg[`SPI_MSB-1:0], pin_s[`PIN_SDI]};
                    if (bit_cnt_reg == `SPI_CNT_LAST) begin
                        spi_rx_word   <= {rx_sh_reg[`SPI_MSB-1:0], pin_s[`PIN_SDI]};
                        spi_rx_strobe <= 1'b1;
                        bit_cnt_reg   <= `SPI_CNT_ZERO;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end
                end
                // rising edge after a sampled bit presents the next one
                if (sclk_rise && (bit_cnt_reg != `SPI_CNT_ZERO)) begin
                    spi_sdo   <= tx_sh_reg[`SPI_MSB];
                    tx_sh_reg <= {tx_sh_reg[`SPI_MSB-1:0], 1'b0};
                end
            end
        end
    end

endmodule // gate_drive_input_control

/* File: sim/gate_drive_checker.sv */
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
// ============================================================
// port checker for the gate drive control block
module gate_drive_checker (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                resetn,
    // pins and configuration
    input wire logic                drive_select_bit0,
    input wire logic                drive_select_bit1,
    input wire logic                drive_select_bit2,
    input wire logic                secondary_override_enable,
    input wire logic                secondary_override_level,
    input wire logic                second_input_analog_mode,
    input wire logic                cmp_above_select,
    input wire logic [`ADC_W-1:0]   cmp_threshold,
    input wire logic                fault_mask,
    input wire logic [`ADC_W-1:0]   adc_value,
    input wire logic                adc_valid,
    input wire logic                spi_cs_n,
    // design outputs
    input wire logic [`STAGE_W-1:0] gate_pullup_outputs,
    input wire logic [`STAGE_W-1:0] gate_pulldown_outputs,
    input wire logic                first_fault_alarm_output,
    input wire logic                cmp_fault_reg,
    input wire logic                shoot_through_guard,
    input wire logic                spi_sdo_oe,
    input wire logic                spi_rx_strobe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // helper terms; windows of 8 cover the 4-5 cycle pin latency
    wire all_high = drive_select_bit0 & drive_select_bit1 & drive_select_bit2;
    wire trip = adc_valid & second_input_analog_mode &
        (cmp_above_select ? adc_value > cmp_threshold : adc_value < cmp_threshold);
    sequence held_off_s; all_high[*8]; endsequence
    sequence no_trip_off_s; (all_high & !trip)[*8]; endsequence
    sequence sec_high_s;
        (secondary_override_enable & secondary_override_level &
         !second_input_analog_mode & !all_high)[*8];
    endsequence
    sequence idle_cs_s; spi_cs_n[*8]; endsequence
    gate_forced_off_a: assert property (held_off_s |->
        gate_pullup_outputs == 2'h0 && gate_pulldown_outputs == 2'h3 &&
        !shoot_through_guard)
        else $error("gate not forced off");
    fault_cleared_a: assert property (no_trip_off_s |-> !cmp_fault_reg)
        else $error("fault not cleared");
    sec_follow_a: assert property (sec_high_s |->
        gate_pulldown_outputs == 2'h0 && gate_pullup_outputs != 2'h0)
        else $error("secondary level not followed");
    guard_off_a: assert property (shoot_through_guard |-> gate_pullup_outputs == 2'h0)
        else $error("guard with gate on");
    stage_excl_a: assert property (!(|gate_pullup_outputs && |gate_pulldown_outputs))
        else $error("pull-up and pull-down both on");
    cmp_trip_a: assert property (trip |=> cmp_fault_reg)
        else $error("comparator trip missed");
    cmp_hold_a: assert property (!cmp_fault_reg && !trip |=> !cmp_fault_reg)
        else $error("fault without trip");
    alarm_follows_a: assert property (first_fault_alarm_output ==
        !($past(cmp_fault_reg) && !$past(fault_mask)))
        else $error("alarm level wrong");
    sdo_release_a: assert property (idle_cs_s |-> !spi_sdo_oe && !spi_rx_strobe)
        else $error("serial port active while deselected");
    strobe_pulse_a: assert property (spi_rx_strobe |=> !spi_rx_strobe)
        else $error("strobe longer than one cycle");
endmodule // gate_drive_checker

bind gate_drive_input_control gate_drive_checker gate_drive_checker_i (.*);

/* File: sim/spi_host_model.sv */
`timescale 1ns/1ns
// ============================================================
// host end of the serial port; clock idles high and stands still
module spi_host_model (
    // pins towards the device
    output reg  spi_sclk,
    output reg  spi_cs_n,
    output reg  spi_sdi,
    input  wire spi_sdo,
    input  wire spi_sdo_oe
);
    // released pin shows the inverse, so a stale bit never matches
    wire sdo_pin = spi_sdo_oe ? spi_sdo : ~spi_sdo;
    initial begin
        spi_sclk = 1'h1;
        spi_cs_n = 1'h1;
        spi_sdi  = 1'h0;
    end
    // one msb-first word; 80 ns period, twice the 40 ns (two cycles per half) the pin filter can follow
    task xfer(input [15:0] w, output [15:0] r);
        integer k;
        begin
            #3 spi_cs_n = 1'h0;
            #200;
            for (k = 15; k >= 0; k = k - 1) begin
                spi_sdi = w[k];
                #40 spi_sclk = 1'h0;
                // read late: the device's pin sync delays sdo by ~45 ns
                #36 r[k] = sdo_pin;
                #4 spi_sclk = 1'h1;
            end
            #200 spi_cs_n = 1'h1;
            #200;
        end
    endtask
    // clock and data toggling with chip select high
    task noise;
        integer k;
        begin
            #3;
            for (k = 0; k < 20; k = k + 1) begin
                spi_sdi = ~spi_sdi;
                #40 spi_sclk = 1'h0;
                #40 spi_sclk = 1'h1;
            end
            #200;
        end
    endtask
endmodule // spi_host_model

/* File: sim/tb.sv */
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
// ============================================================
// bench top: gate table, comparator, serial frame
module tb;
    // pins named as the ports, so instances connect by name
    reg clk_sys = 1'h0, resetn = 1'h0;
    reg drive_select_bit0 = 1'h1, drive_select_bit1 = 1'h0, drive_select_bit2 = 1'h0;
    reg primary_override_enable = 1'h0, primary_override_level = 1'h0;
    reg pwm_positive_input = 1'h0, pwm_negative_input = 1'h0;
    reg secondary_override_enable = 1'h0, secondary_override_level = 1'h0;
    reg safe_state_level_select = 1'h0, second_input_analog_mode = 1'h0;
    reg cmp_above_select = 1'h0, fault_mask = 1'h0, adc_valid = 1'h0;
    reg [`ADC_W-1:0] cmp_threshold = 10'h100, adc_value = 10'h000;
    reg [`SPI_MSB:0] spi_tx_word = 16'ha5c3, got;
    wire [`STAGE_W-1:0] gate_pullup_outputs, gate_pulldown_outputs;
    wire first_fault_alarm_output, cmp_fault_reg, shoot_through_guard;
    wire spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, spi_rx_strobe;
    wire [`SPI_MSB:0] spi_rx_word;
    integer n_errors = 0, checks = 0, cyc = 0, nstb = 0, k;
    // {selects, pri en, pri level, pos, neg, sec en, sec level}
    localparam [71:0] rows = {9'h048, 9'h040, 9'h08c, 9'h0f0, 9'h128, 9'h023, 9'h1c8, 9'h086};
    gate_drive_input_control gate_drive_input_control_i (.*);
    spi_host_model spi_host_model_i (.*);
    always #5 clk_sys = ~clk_sys;
    // strobe count and hang guard
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (spi_rx_strobe === 1'h1) nstb = nstb + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("wrong value %s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d, n_errors %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // drive one pin row, then compare against the priority order
    task gate_case(input [8:0] r);
        reg on;
        reg [1:0] m;
        reg [2:0] s;
        begin
            @(negedge clk_sys);
            {drive_select_bit2, drive_select_bit1, drive_select_bit0, primary_override_enable,
             primary_override_level, pwm_positive_input, pwm_negative_input,
             secondary_override_enable, secondary_override_level} = r;
            s = r[8:6];
            m = (s[1:0] == 2'h0) ? 2'h3 : s[1:0];
            on = (s != 3'h7) & (r[1] ? (second_input_analog_mode ? safe_state_level_select : r[0])
                : (r[5] ? r[4] : r[3] & ~r[2]));
            repeat (10) @(posedge clk_sys);
            #1;
            chk("pullup", 16'(on ? m : 2'h0), 16'(gate_pullup_outputs));
            chk("pulldown", 16'(on ? 2'h0 : (s[2] ? 2'h3 : m)), 16'(gate_pulldown_outputs));
            chk("guard", 16'(r[3] & r[2] & ~r[5] & ~r[1] & (s != 3'h7)),
                16'(shoot_through_guard));
        end
    endtask
    // one adc sample, then clear through all selects high
    task cmp_case(input a, input [9:0] v, input e);
        begin
            @(negedge clk_sys);
            cmp_above_select = a;
            adc_value = v;
            adc_valid = 1'h1;
            @(negedge clk_sys);
            adc_valid = 1'h0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk("cmp fault", 16'(e), 16'(cmp_fault_reg));
            chk("alarm", 16'(!(e && !fault_mask)), 16'(first_fault_alarm_output));
            gate_case(9'h1c8);
            chk("cleared", 16'h0, 16'(cmp_fault_reg));
            gate_case(9'h048);
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        resetn = 1'h1;
        repeat (10) @(negedge clk_sys);
        for (k = 0; k < 8; k = k + 1)
            gate_case(rows[k*9 +: 9]);
        gate_case(9'h1cc);
        $display("test gate table done");
        @(negedge clk_sys);
        second_input_analog_mode = 1'h1;
        safe_state_level_select = 1'h1;
        gate_case(9'h042);
        cmp_case(1'h1, 10'h100, 1'h0);
        cmp_case(1'h1, 10'h101, 1'h1);
        cmp_case(1'h0, 10'h0ff, 1'h1);
        @(negedge clk_sys);
        fault_mask = 1'h1;
        cmp_case(1'h0, 10'h0ff, 1'h1);
        @(negedge clk_sys);
        second_input_analog_mode = 1'h0;
        cmp_case(1'h1, 10'h3ff, 1'h0);
        $display("test comparator done");
        chk("sdo enable", 16'h0, 16'(spi_sdo_oe));
        spi_host_model_i.noise;
        chk("strobes", 16'h0, 16'(nstb));
        spi_host_model_i.xfer(16'h3c96, got);
        chk("rx word", 16'h3c96, spi_rx_word);
        chk("sdo word", spi_tx_word, got);
        chk("strobes", 16'h1, 16'(nstb));
        $display("test serial frame done");
        final_report;
    end
endmodule // tb
